/* src/aei_exc_unit.sv */
// address error and interrupt acceptance sequencer
`timescale 1ns/1ps
// What the document requires
// [RULE1] address error handling starts after bus cycle end and instruction completion
// [RULE2] address error pushes status word then next-instruction program counter
// [RULE3] address error handler fetched from its vector, jumped to without delay slot
// [RULE4] both DMA engines' address errors share vector 10
// [RULE5] handler reads both DMA error flags to learn which engine failed
// [RULE6] sources: NMI, user break, debug, 15 encoded levels, 4 pins, peripherals
// [RULE7] priority levels run 0 lowest to 16 highest
// [RULE8] NMI is level 16 and always accepted regardless of mask; the code still holds it off while intr_allowed is low
// [RULE9] user break and debug interrupts have fixed level 15
// [RULE10] encoded level pins carry levels 1 to 15, used directly as priority
// [RULE11] pin and peripheral levels come from priority registers, 0 to 15 only
// [RULE12] simultaneous requests: highest priority is taken first
// [RULE13] maskable interrupt taken only when level exceeds the mask field
// [RULE14] accepted interrupt pushes status word and program counter first
// [RULE15] accepted level goes to mask field; NMI loads 15
// [RULE16] each source has its own vector; handler fetched from that entry
module aei_exc_unit (
  input wire logic sys_clk,
  input wire logic rst_b,
  // external pins
  input wire logic nmi_pin,
  input wire logic [3:0] encoded_level_pins,
  input wire logic [aei_pkg::NUM_IRQ-1:0] irq_pins,
  // on-chip requesters
  input wire logic user_break_req,
  input wire logic debug_interface_req,
  input wire logic [aei_pkg::NUM_PERIPH-1:0] periph_req,
  input wire logic [aei_pkg::NUM_IRQ*aei_pkg::LVL_W-1:0] pin_request_priority,
  input wire logic [aei_pkg::NUM_PERIPH*aei_pkg::LVL_W-1:0] periph_priority,
  // address error events
  input wire logic cpu_addr_err,
  input wire logic dma_addr_err,
  input wire logic eth_dma_addr_err,
  // core state
  input wire logic bus_cycle_done,
  input wire logic instr_done,
  input wire logic intr_allowed,
  input wire logic [aei_pkg::AW-1:0] status_word,
  input wire logic [aei_pkg::AW-1:0] next_pc,
  input wire logic [aei_pkg::AW-1:0] stack_ptr,
  input wire logic [aei_pkg::AW-1:0] vector_base,
  // stack write port
  output logic stk_wr_req,
  output logic [aei_pkg::AW-1:0] stk_wr_addr,
  output logic [aei_pkg::AW-1:0] stk_wr_data,
  input wire logic stk_wr_ack,
  // vector read port
  output logic vec_rd_req,
  output logic [aei_pkg::AW-1:0] vec_rd_addr,
  input wire logic vec_rd_ack,
  input wire logic [aei_pkg::AW-1:0] vec_rd_data,
  // core update
  output logic pc_load,
  output logic [aei_pkg::AW-1:0] pc_load_value,
  output logic sp_load,
  output logic [aei_pkg::AW-1:0] sp_load_value,
  output logic mask_load,
  output logic [aei_pkg::LVL_W-1:0] mask_load_value,
  output logic int_ack,
  output logic [aei_pkg::SRC_W-1:0] int_ack_src,
  output logic exc_busy
);

  // ---------------------------------------------------------------
  // function: vector table entry address
  // ---------------------------------------------------------------
  function automatic logic [aei_pkg::AW-1:0] vec_addr(input logic [aei_pkg::AW-1:0] base,
                                                      input logic [aei_pkg::VEC_W-1:0] vec);
    logic [aei_pkg::AW-1:0] off;
    off = {{(aei_pkg::AW-aei_pkg::VEC_W){1'b0}}, vec} << aei_pkg::VEC_SHIFT;
    return base + off;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic nmi_s;
  logic [3:0] enc_s;
  logic [aei_pkg::NUM_IRQ-1:0] irq_s;

  aei_sync2 #(.W(1)) u_sync_nmi (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(nmi_pin),
    .sync_out(nmi_s)
  );

  aei_sync2 #(.W(4 + aei_pkg::NUM_IRQ)) u_sync_lvl (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({encoded_level_pins, irq_pins}),
    .sync_out({enc_s, irq_s})
  );

  // ---------------------------------------------------------------
  // maskable source vector and levels
  // ---------------------------------------------------------------
  logic [aei_pkg::NUM_SRC-1:0] src_req;
  logic [aei_pkg::NUM_SRC*aei_pkg::LVL_W-1:0] src_lvl;
  logic win_valid;
  logic [aei_pkg::SRC_W-1:0] win_idx;
  logic [aei_pkg::LVL_W-1:0] win_lvl;

  // encoded pins: zero means no request, otherwise the code is the level
  always_comb begin
    src_req = {periph_req, irq_s, (enc_s != 4'h0), debug_interface_req, user_break_req}; // [RULE6]
    src_lvl = {periph_priority, // [RULE11]
               pin_request_priority,
               enc_s, // [RULE10]
               aei_pkg::LVL_FIXED_BRK, // [RULE9]
               aei_pkg::LVL_FIXED_BRK};
  end

  aei_prio_arb u_arb (
    .src_req(src_req),
    .src_lvl(src_lvl),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // source slot to vector number
  function automatic logic [aei_pkg::VEC_W-1:0] src_vec(input logic [aei_pkg::SRC_W-1:0] idx,
                                                        input logic [3:0] enc);
    logic [aei_pkg::VEC_W-1:0] v;
    v = aei_pkg::VEC_UBRK;
    if (idx == aei_pkg::SRC_UBRK) begin
      v = aei_pkg::VEC_UBRK;
    end else if (idx == aei_pkg::SRC_DBG) begin
      v = aei_pkg::VEC_DBG;
    end else if (idx == aei_pkg::SRC_ENC) begin
      v = aei_pkg::VEC_ENC_BASE + {4'h0, enc};
    end else if (idx < aei_pkg::SRC_PER0) begin
      v = aei_pkg::VEC_IRQ_BASE + {2'h0, idx - aei_pkg::SRC_IRQ0};
    end else begin
      v = aei_pkg::VEC_PER_BASE + {2'h0, idx - aei_pkg::SRC_PER0};
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // pending event flags
  // ---------------------------------------------------------------
  logic nmi_s_dly_q;
  logic nmi_s_dly_d;
  logic nmi_pend_q;
  logic nmi_pend_d;
  logic cpu_ae_q;
  logic cpu_ae_d;
  logic dma_ae_q;
  logic dma_ae_d;
  logic take_ae;
  logic take_nmi;
  logic take_int;
  logic at_boundary;
  logic [aei_pkg::LVL_W-1:0] cur_mask;

  aei_pkg::aei_state_t st_q;
  aei_pkg::aei_state_t st_d;

  always_comb begin
    cur_mask = status_word[aei_pkg::SW_MASK_LSB +: aei_pkg::LVL_W];
    at_boundary = (st_q == aei_pkg::AEI_IDLE) && bus_cycle_done && instr_done; // [RULE1]
    take_ae = at_boundary && (cpu_ae_q || dma_ae_q);
    take_nmi = at_boundary && !take_ae && intr_allowed && nmi_pend_q; // [RULE8]
    take_int = at_boundary && !take_ae && !take_nmi && intr_allowed && win_valid
               && (win_lvl > cur_mask); // [RULE13]
    nmi_s_dly_d = nmi_s;
    // a new event in the clear cycle survives: set wins over clear
    nmi_pend_d = (nmi_pend_q && !take_nmi) || (nmi_s && !nmi_s_dly_q);
    cpu_ae_d = (cpu_ae_q && !take_ae) || cpu_addr_err;
    dma_ae_d = (dma_ae_q && !(take_ae && !cpu_ae_q)) || dma_addr_err || eth_dma_addr_err;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      nmi_s_dly_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      cpu_ae_q <= 1'b0;
      dma_ae_q <= 1'b0;
    end else begin
      nmi_s_dly_q <= nmi_s_dly_d;
      nmi_pend_q <= nmi_pend_d;
      cpu_ae_q <= cpu_ae_d;
      dma_ae_q <= dma_ae_d;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic [aei_pkg::AW-1:0] sw_q;
  logic [aei_pkg::AW-1:0] sw_d;
  logic [aei_pkg::AW-1:0] pc_q;
  logic [aei_pkg::AW-1:0] pc_d;
  logic [aei_pkg::AW-1:0] sp_q;
  logic [aei_pkg::AW-1:0] sp_d;
  logic [aei_pkg::VEC_W-1:0] vec_q;
  logic [aei_pkg::VEC_W-1:0] vec_d;
  logic [aei_pkg::AW-1:0] handler_q;
  logic [aei_pkg::AW-1:0] handler_d;
  logic upd_mask_q;
  logic upd_mask_d;
  logic [aei_pkg::LVL_W-1:0] new_mask_q;
  logic [aei_pkg::LVL_W-1:0] new_mask_d;
  logic ack_q;
  logic ack_d;
  logic [aei_pkg::SRC_W-1:0] ack_src_q;
  logic [aei_pkg::SRC_W-1:0] ack_src_d;

  always_comb begin
    st_d = st_q;
    sw_d = sw_q;
    pc_d = pc_q;
    sp_d = sp_q;
    vec_d = vec_q;
    handler_d = handler_q;
    upd_mask_d = upd_mask_q;
    new_mask_d = new_mask_q;
    ack_d = 1'b0;
    ack_src_d = ack_src_q;
    case (st_q)
      aei_pkg::AEI_IDLE: begin
        if (take_ae || take_nmi || take_int) begin
          st_d = aei_pkg::AEI_PUSH_SW;
          sw_d = status_word;
          pc_d = next_pc; // [RULE2]
          sp_d = stack_ptr;
          upd_mask_d = !take_ae;
        end
        // the core's own address error outranks a DMA one when both wait
        if (take_ae) begin
          vec_d = cpu_ae_q ? aei_pkg::VEC_CPU_ADDR_ERR : aei_pkg::VEC_DMA_ADDR_ERR; // [RULE4]
        end else if (take_nmi) begin
          vec_d = aei_pkg::VEC_NMI;
          new_mask_d = aei_pkg::LVL_NMI_MASK; // [RULE15]
        end else if (take_int) begin
          vec_d = src_vec(win_idx, enc_s); // [RULE16]
          new_mask_d = win_lvl; // [RULE15]
          ack_d = 1'b1;
          ack_src_d = win_idx;
        end
      end
      aei_pkg::AEI_PUSH_SW: begin
        if (stk_wr_ack) begin
          st_d = aei_pkg::AEI_PUSH_PC; // [RULE14]
        end
      end
      aei_pkg::AEI_PUSH_PC: begin
        if (stk_wr_ack) begin
          st_d = aei_pkg::AEI_FETCH;
        end
      end
      aei_pkg::AEI_FETCH: begin
        if (vec_rd_ack) begin
          st_d = aei_pkg::AEI_JUMP; // [RULE3]
          handler_d = vec_rd_data;
        end
      end
      aei_pkg::AEI_JUMP: begin
        st_d = aei_pkg::AEI_IDLE;
      end
      default: begin
        st_d = aei_pkg::AEI_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q <= aei_pkg::AEI_IDLE;
      sw_q <= '0;
      pc_q <= '0;
      sp_q <= '0;
      vec_q <= '0;
      handler_q <= '0;
      upd_mask_q <= 1'b0;
      new_mask_q <= aei_pkg::LVL_NONE;
      ack_q <= 1'b0;
      ack_src_q <= '0;
    end else begin
      st_q <= st_d;
      sw_q <= sw_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      vec_q <= vec_d;
      handler_q <= handler_d;
      upd_mask_q <= upd_mask_d;
      new_mask_q <= new_mask_d;
      ack_q <= ack_d;
      ack_src_q <= ack_src_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // status word goes in the higher slot, program counter below it
  always_comb begin
    stk_wr_req = (st_q == aei_pkg::AEI_PUSH_SW) || (st_q == aei_pkg::AEI_PUSH_PC);
    stk_wr_addr = (st_q == aei_pkg::AEI_PUSH_PC) ? sp_q - aei_pkg::STK_FRAME : sp_q - aei_pkg::STK_SLOT; // [RULE2]
    stk_wr_data = (st_q == aei_pkg::AEI_PUSH_PC) ? pc_q : sw_q; // [RULE14]
    vec_rd_req = (st_q == aei_pkg::AEI_FETCH);
    vec_rd_addr = vec_addr(vector_base, vec_q); // [RULE16]
    // single-cycle load with no slot instruction: the jump is not delayed
    pc_load = (st_q == aei_pkg::AEI_JUMP); // [RULE3]
    pc_load_value = handler_q;
    sp_load = (st_q == aei_pkg::AEI_JUMP);
    sp_load_value = sp_q - aei_pkg::STK_FRAME;
    mask_load = (st_q == aei_pkg::AEI_JUMP) && upd_mask_q; // [RULE15]
    mask_load_value = new_mask_q;
    int_ack = ack_q;
    int_ack_src = ack_src_q;
    exc_busy = (st_q != aei_pkg::AEI_IDLE);
  end

endmodule

/* src/aei_pkg.sv */
// shared constants and types for the exception acceptance unit
package aei_pkg;

  // ---------------------------------------------------------------
  // widths and source counts
  // ---------------------------------------------------------------
  localparam int unsigned AW = 32;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned NUM_IRQ = 4;
  localparam int unsigned NUM_PERIPH = 33;
  // maskable sources: user break, debug, encoded level, 4 pins, peripherals
  localparam int unsigned NUM_SRC = 3 + NUM_IRQ + NUM_PERIPH;
  localparam int unsigned SRC_W = 6;

  // ---------------------------------------------------------------
  // source slots in the maskable request vector
  // ---------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_UBRK = 6'h00;
  localparam logic [SRC_W-1:0] SRC_DBG = 6'h01;
  localparam logic [SRC_W-1:0] SRC_ENC = 6'h02;
  localparam logic [SRC_W-1:0] SRC_IRQ0 = 6'h03;
  localparam logic [SRC_W-1:0] SRC_PER0 = 6'h07;

  // ---------------------------------------------------------------
  // priority levels
  // ---------------------------------------------------------------
  localparam logic [LVL_W-1:0] LVL_FIXED_BRK = 4'hF;
  localparam logic [LVL_W-1:0] LVL_NMI_MASK = 4'hF;
  localparam logic [LVL_W-1:0] LVL_NONE = 4'h0;

  // ---------------------------------------------------------------
  // vector numbers
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_CPU_ADDR_ERR = 8'h09;
  localparam logic [VEC_W-1:0] VEC_DMA_ADDR_ERR = 8'h0A;
  localparam logic [VEC_W-1:0] VEC_NMI = 8'h0B;
  localparam logic [VEC_W-1:0] VEC_UBRK = 8'h0C;
  localparam logic [VEC_W-1:0] VEC_DBG = 8'h0E;
  localparam logic [VEC_W-1:0] VEC_ENC_BASE = 8'h40;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 8'h50;
  localparam logic [VEC_W-1:0] VEC_PER_BASE = 8'h60;

  // ---------------------------------------------------------------
  // status word layout and stack frame
  // ---------------------------------------------------------------
  localparam int unsigned SW_MASK_LSB = 4;
  localparam logic [AW-1:0] STK_SLOT = 32'h0000_0004;
  localparam logic [AW-1:0] STK_FRAME = 32'h0000_0008;
  localparam int unsigned VEC_SHIFT = 2;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    AEI_IDLE = 5'b00001,
    AEI_PUSH_SW = 5'b00010,
    AEI_PUSH_PC = 5'b00100,
    AEI_FETCH = 5'b01000,
    AEI_JUMP = 5'b10000
  } aei_state_t;

endpackage

/* src/aei_sync2.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module aei_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

/* src/aei_prio_arb.sv */
// highest-level pick among the maskable interrupt sources
`timescale 1ns/1ps
module aei_prio_arb (
  input wire logic [aei_pkg::NUM_SRC-1:0] src_req,
  input wire logic [aei_pkg::NUM_SRC*aei_pkg::LVL_W-1:0] src_lvl,
  output logic win_valid,
  output logic [aei_pkg::SRC_W-1:0] win_idx,
  output logic [aei_pkg::LVL_W-1:0] win_lvl
);
  // equal levels resolve to the lower slot, so the scan only replaces on a strict win
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    win_lvl = aei_pkg::LVL_NONE;
    for (int i = 0; i < aei_pkg::NUM_SRC; i++) begin
      if (src_req[i] && (!win_valid || src_lvl[i*aei_pkg::LVL_W +: aei_pkg::LVL_W] > win_lvl)) begin // [RULE12]
        win_valid = 1'b1;
        win_idx = i[aei_pkg::SRC_W-1:0];
        win_lvl = src_lvl[i*aei_pkg::LVL_W +: aei_pkg::LVL_W];
      end
    end
  end
endmodule

/* tb/aei_exc_unit_assertions.sv */
// concurrent property checker for the exception acceptance unit
`timescale 1ns/1ps
module aei_exc_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bus_cycle_done,
  input wire logic instr_done,
  input wire logic [31:0] status_word,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] stack_ptr,
  input wire logic [131:0] periph_priority,
  input wire logic stk_wr_req,
  input wire logic [31:0] stk_wr_addr,
  input wire logic [31:0] stk_wr_data,
  input wire logic stk_wr_ack,
  input wire logic vec_rd_req,
  input wire logic vec_rd_ack,
  input wire logic [31:0] vec_rd_data,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_value,
  input wire logic sp_load,
  input wire logic [31:0] sp_load_value,
  input wire logic mask_load,
  input wire logic [3:0] mask_load_value,
  input wire logic int_ack,
  input wire logic [5:0] int_ack_src,
  input wire logic exc_busy
);
  logic [3:0] per_lvl;
  // only meaningful while the acknowledged slot is a peripheral one
  always_comb per_lvl = periph_priority[4*(int_ack_src-6'h07) +: 4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // frame steps
  // ----------------------------------------------------------------
  sequence s_sw_push;
    stk_wr_req && stk_wr_addr == stack_ptr - 32'h4 && stk_wr_data == status_word;
  endsequence
  sequence s_pc_push;
    stk_wr_req && stk_wr_addr == stack_ptr - 32'h8 && stk_wr_data == next_pc;
  endsequence
  sequence s_fetch;
    vec_rd_req && vec_rd_ack;
  endsequence
  a_boundary_wait: assert property (
    $rose(exc_busy) |-> $past(bus_cycle_done) && $past(instr_done)) else $error("exception started off a boundary");
  a_sw_first: assert property (
    $rose(exc_busy) |-> s_sw_push) else $error("status word not pushed first");
  a_pc_second: assert property (
    s_sw_push ##0 stk_wr_ack |=> s_pc_push) else $error("counter push does not follow");
  a_jump_after_fetch: assert property (
    s_fetch |=> pc_load && pc_load_value == $past(vec_rd_data)) else $error("jump not right after fetch");
  a_frame_drop: assert property (
    pc_load |-> sp_load && sp_load_value == stack_ptr - 32'h8) else $error("stack pointer update wrong");
  a_seq_ends: assert property (
    pc_load |=> !exc_busy) else $error("busy after jump");
  a_ack_at_start: assert property (
    int_ack |-> $rose(exc_busy) ##0 s_sw_push) else $error("ack outside acceptance");
  a_fixed_level: assert property (
    int_ack && int_ack_src <= 6'h01 |-> ##[3:60] mask_load && mask_load_value == 4'hF)
    else $error("fixed level not loaded");
  a_ubrk_masked: assert property (
    int_ack && int_ack_src <= 6'h01 |-> status_word[7:4] != 4'hF) else $error("level 15 taken at mask 15");
  a_mask_compare: assert property (
    int_ack && int_ack_src >= 6'h07 |-> per_lvl > status_word[7:4]) else $error("peripheral taken at mask");
  a_load_with_jump: assert property (
    mask_load |-> pc_load) else $error("mask load apart from jump");
endmodule
bind aei_exc_unit aei_exc_chk u_chk (.sys_clk, .rst_b, .bus_cycle_done, .instr_done, .status_word, .next_pc,
  .stack_ptr, .periph_priority, .stk_wr_req, .stk_wr_addr, .stk_wr_data, .stk_wr_ack, .vec_rd_req, .vec_rd_ack,
  .vec_rd_data, .pc_load, .pc_load_value, .sp_load, .sp_load_value, .mask_load, .mask_load_value, .int_ack,
  .int_ack_src, .exc_busy);

/* tb/aei_mem_model.sv */
// stack and vector table responder standing in for core memory
`timescale 1ns/1ps
module aei_mem_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic stk_wr_req,
  input wire logic vec_rd_req,
  input wire logic [31:0] vec_rd_addr,
  output logic stk_wr_ack,
  output logic vec_rd_ack,
  output logic [31:0] vec_rd_data
);
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic go;
  // slow mode stalls every access two cycles so held requests get exercised
  always_comb begin
    go = !slow || wait_q == 2'h2;
    stk_wr_ack = stk_wr_req && go;
    vec_rd_ack = vec_rd_req && go;
    // off the ack the data bus shows the inverse, never a stale handler
    vec_rd_data = vec_rd_addr ^ (vec_rd_ack ? 32'hC000_0000 : 32'h3FFF_FFFF);
    wait_d = (stk_wr_req || vec_rd_req) && !go ? wait_q + 2'h1 : 2'h0;
  end
  always_ff @(posedge sys_clk) begin
    wait_q <= rst_b ? wait_d : 2'h0;
  end
endmodule

/* tb/aei_exc_unit_tb.sv */
// self-checking bench for the exception acceptance unit
`timescale 1ns/1ps
module aei_exc_unit_tb;
  typedef struct packed {
    logic [3:0] k;
    logic [5:0] i;
    logic [3:0] l;
    logic [3:0] m;
    logic a;
    logic [7:0] v;
    logic ml;
    logic [3:0] mv;
    logic [5:0] s;
  } aei_row_t;
  localparam logic [31:0] SP = 32'h0000_8000;
  localparam logic [31:0] VB = 32'h0000_1000;
  localparam logic [31:0] NPC = 32'h0000_2468;
  // kind 0..2 address errors, 3 nmi, 4 ubrk, 5 debug, 6 encoded, 7 pin, 8 peripheral
  localparam aei_row_t rows [16] = '{
    '{4'h0, 6'h00, 4'h0, 4'hF, 1'b1, 8'h09, 1'b0, 4'h0, 6'h00}, '{4'h1, 6'h00, 4'h0, 4'hF, 1'b1, 8'h0A, 1'b0, 4'h0, 6'h00},
    '{4'h2, 6'h00, 4'h0, 4'hF, 1'b1, 8'h0A, 1'b0, 4'h0, 6'h00}, '{4'h3, 6'h00, 4'h0, 4'hF, 1'b1, 8'h0B, 1'b1, 4'hF, 6'h00},
    '{4'h4, 6'h00, 4'h0, 4'hE, 1'b1, 8'h0C, 1'b1, 4'hF, 6'h00}, '{4'h4, 6'h00, 4'h0, 4'hF, 1'b0, 8'h00, 1'b0, 4'h0, 6'h00},
    '{4'h5, 6'h00, 4'h0, 4'hE, 1'b1, 8'h0E, 1'b1, 4'hF, 6'h01}, '{4'h6, 6'h00, 4'h1, 4'h0, 1'b1, 8'h41, 1'b1, 4'h1, 6'h02},
    '{4'h6, 6'h00, 4'hF, 4'hE, 1'b1, 8'h4F, 1'b1, 4'hF, 6'h02}, '{4'h6, 6'h00, 4'h7, 4'h7, 1'b0, 8'h00, 1'b0, 4'h0, 6'h00},
    '{4'h7, 6'h00, 4'h3, 4'h2, 1'b1, 8'h50, 1'b1, 4'h3, 6'h03}, '{4'h7, 6'h03, 4'hF, 4'h0, 1'b1, 8'h53, 1'b1, 4'hF, 6'h06},
    '{4'h8, 6'h00, 4'h5, 4'h4, 1'b1, 8'h60, 1'b1, 4'h5, 6'h07}, '{4'h8, 6'h20, 4'h1, 4'h0, 1'b1, 8'h80, 1'b1, 4'h1, 6'h27},
    '{4'h8, 6'h05, 4'h0, 4'h0, 1'b0, 8'h00, 1'b0, 4'h0, 6'h00}, '{4'h8, 6'h09, 4'h9, 4'h9, 1'b0, 8'h00, 1'b0, 4'h0, 6'h00}};
  logic sys_clk = 1'b0;
  logic rst_b, nmi_pin, user_break_req, debug_interface_req, cpu_addr_err, dma_addr_err, eth_dma_addr_err;
  logic bus_cycle_done, instr_done, intr_allowed, slow, stk_wr_req, stk_wr_ack, vec_rd_req, vec_rd_ack;
  logic pc_load, sp_load, mask_load, int_ack, exc_busy, mls, pcs;
  logic [3:0] encoded_level_pins, irq_pins, mask_load_value, mvs;
  logic [32:0] periph_req;
  logic [15:0] pin_request_priority;
  logic [131:0] periph_priority;
  logic [31:0] status_word, stk_wr_addr, stk_wr_data, vec_rd_addr, vec_rd_data, pc_load_value, sp_load_value;
  logic [31:0] va, pcv, spv;
  logic [31:0] wa[$], wd[$];
  logic [5:0] int_ack_src, ss;
  int miscompares = 0, n_compared = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  aei_exc_unit uut (.sys_clk, .rst_b, .nmi_pin, .encoded_level_pins, .irq_pins, .user_break_req,
    .debug_interface_req, .periph_req, .pin_request_priority, .periph_priority, .cpu_addr_err, .dma_addr_err,
    .eth_dma_addr_err, .bus_cycle_done, .instr_done, .intr_allowed, .status_word, .next_pc(NPC),
    .stack_ptr(SP), .vector_base(VB), .stk_wr_req, .stk_wr_addr, .stk_wr_data, .stk_wr_ack, .vec_rd_req,
    .vec_rd_addr, .vec_rd_ack, .vec_rd_data, .pc_load, .pc_load_value, .sp_load, .sp_load_value, .mask_load,
    .mask_load_value, .int_ack, .int_ack_src, .exc_busy);
  aei_mem_model u_mem (.sys_clk, .rst_b, .slow, .stk_wr_req, .vec_rd_req, .vec_rd_addr, .stk_wr_ack,
    .vec_rd_ack, .vec_rd_data);
  // ----------------------------------------------------------------
  // monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (stk_wr_req && stk_wr_ack) begin
      wa.push_back(stk_wr_addr);
      wd.push_back(stk_wr_data);
    end
    if (vec_rd_req && vec_rd_ack) va = vec_rd_addr;
    if (pc_load) begin
      pcs = 1'b1;
      pcv = pc_load_value;
      spv = sp_load_value;
    end
    if (mask_load) begin
      mls = 1'b1;
      mvs = mask_load_value;
    end
    if (int_ack) ss = int_ack_src;
    if (cyc == 4000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task req(input logic [3:0] k, input logic [5:0] i, input logic [3:0] l, input logic on);
    case (k)
      4'h0: cpu_addr_err <= on;
      4'h1: dma_addr_err <= on;
      4'h2: eth_dma_addr_err <= on;
      4'h3: nmi_pin <= on;
      4'h4: user_break_req <= on;
      4'h5: debug_interface_req <= on;
      4'h6: encoded_level_pins <= on ? l : 4'h0;
      4'h7: begin
        irq_pins[i] <= on;
        pin_request_priority[4*i +: 4] <= l;
      end
      default: begin
        periph_req[i] <= on;
        periph_priority[4*i +: 4] <= l;
      end
    endcase
  endtask
  // waits for acceptance, releases the request, then checks the whole frame
  task fin(input logic [3:0] k, input logic [5:0] i, input logic [3:0] l, input logic a, input logic [7:0] v,
           input logic ml, input logic [3:0] mv, input logic [5:0] s);
    int n;
    wa.delete();
    wd.delete();
    pcs = 1'b0;
    mls = 1'b0;
    ss = 6'h3F;
    #1;
    for (n = 0; n < 12 && exc_busy !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("accepted", exc_busy, a);
    @(posedge sys_clk);
    req(k, i, l, 1'b0);
    if (a) begin
      for (n = 0; n < 40 && pcs !== 1'b1; n++) begin
        @(posedge sys_clk);
        #1;
      end
      chk("sw_push_addr", wa[0], SP - 32'h4);
      chk("sw_push_data", wd[0], status_word);
      chk("pc_push_addr", wa[1], SP - 32'h8);
      chk("pc_push_data", wd[1], NPC);
      chk("vector_addr", va, VB + {22'h0, v, 2'h0});
      chk("handler", pcv, (VB + {22'h0, v, 2'h0}) ^ 32'hC000_0000);
      chk("stack_ptr", spv, SP - 32'h8);
      chk("mask_load", mls, ml);
      if (ml) chk("mask_value", mvs, mv);
      if (k > 4'h3) chk("source", ss, s);
    end
  endtask
  task run(input aei_row_t r);
    @(posedge sys_clk);
    slow <= ~slow;
    status_word <= {24'hA5A5A5, r.m, 4'h1};
    req(r.k, r.i, r.l, 1'b1);
    if (r.k < 4'h3) begin
      @(posedge sys_clk);
      req(r.k, r.i, r.l, 1'b0);
    end
    fin(r.k, r.i, r.l, r.a, r.v, r.ml, r.mv, r.s);
    repeat (4) @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, nmi_pin, user_break_req, debug_interface_req, cpu_addr_err, dma_addr_err, eth_dma_addr_err} = 7'h00;
    {encoded_level_pins, irq_pins, pin_request_priority, slow} = 25'h0;
    {periph_req, periph_priority} = 165'h0;
    {bus_cycle_done, instr_done, intr_allowed} = 3'h7;
    status_word = 32'h0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("busy_after_reset", exc_busy, 1'b0);
    chk("push_after_reset", stk_wr_req, 1'b0);
    for (int r = 0; r < 16; r++) begin
      run(rows[r]);
    end
    // error held pending until both bus cycle and instruction are done
    @(posedge sys_clk);
    {instr_done, bus_cycle_done, dma_addr_err} <= 3'h1;
    @(posedge sys_clk);
    dma_addr_err <= 1'b0;
    repeat (4) @(posedge sys_clk);
    instr_done <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("early_start", exc_busy, 1'b0);
    @(posedge sys_clk);
    bus_cycle_done <= 1'b1;
    fin(4'h1, 6'h00, 4'h0, 1'b1, 8'h0A, 1'b0, 4'h0, 6'h00);
    repeat (4) @(posedge sys_clk);
    // three requests made pending together under a full mask, then unmasked
    @(posedge sys_clk);
    status_word <= {24'hA5A5A5, 4'hF, 4'h1};
    req(4'h8, 6'h03, 4'h7, 1'b1);
    req(4'h7, 6'h01, 4'hC, 1'b1);
    req(4'h6, 6'h00, 4'h9, 1'b1);
    repeat (4) @(posedge sys_clk);
    status_word <= {24'hA5A5A5, 4'h0, 4'h1};
    // unmasked but blocked by the core: nothing may start until it allows interrupts
    intr_allowed <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("blocked", exc_busy, 1'b0);
    @(posedge sys_clk);
    intr_allowed <= 1'b1;
    fin(4'h7, 6'h01, 4'hC, 1'b1, 8'h51, 1'b1, 4'hC, 6'h04);
    fin(4'h6, 6'h00, 4'h9, 1'b1, 8'h49, 1'b1, 4'h9, 6'h02);
    fin(4'h8, 6'h03, 4'h7, 1'b1, 8'h63, 1'b1, 4'h7, 6'h0A);
    end_of_test();
  end
endmodule
